// file: rtl/sfp_consts.svh
`ifndef SFP_CONSTS_SVH
`define SFP_CONSTS_SVH

// Read command codes that switch the lanes to output
`define SFP_CMD_READ_X1   8'h0B
`define SFP_CMD_READ_X2   8'h3B
`define SFP_CMD_READ_X4   8'h6B

// Frame layout after the command byte
`define SFP_ADDR_BYTES    3'h3
`define SFP_DUMMY_CLKS    4'h8

// Bit positions and counts
`define SFP_BYTE_MSB      3
`define SFP_BITS_PER_BYTE 4'h8
`define SFP_LAST_BIT      3'h7

// Reset values
`define SFP_CS_N_RST      1'h1
`define SFP_BYTE_RST      8'h00

`endif

// file: rtl/sfp_front.sv
// Functional notes
// RULE1: Device counts as selected only while active-low chip select is held low.
// RULE2: Releasing chip select deselects, enters standby and floats all outputs.
// RULE3: While deselected, serial input is ignored; no bits are accepted.
// RULE4: Operations start on chip select falling and end on it rising.
// RULE5: Standby waits until a running program or erase finishes.
// RULE6: Input bits are captured on rising serial clock edges.
// RULE7: Output data changes on falling serial clock edges.
// RULE8: Host sends command, address and write data on the single input lane.
// RULE9: Dual and quad reads turn lane zero into a driven output lane.
// RULE10: Works in clock modes 0 and 3, idle low or high.
// RULE11: Command byte first, then address bytes, each most significant bit first.
`timescale 1ns/1ps
`include "sfp_consts.svh"

module sfp_front (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  // Link pins
  input  wire logic       sck_i,
  input  wire logic       cs_n_i,
  input  wire logic       bidir_lane_zero_i,
  output logic            bidir_lane_zero_o,
  output logic            bidir_lane_zero_oe_o,
  output logic            lane_one_o,
  output logic            lane_one_oe_o,
  output logic [1:0]      lane_hi_o,
  output logic            lane_hi_oe_o,
  // Array side
  input  wire logic       busy_i,
  input  wire logic [7:0] rd_data_i,
  input  wire logic       rd_valid_i,
  output logic            rd_req_o,
  output logic            byte_valid_o,
  output logic [7:0]      byte_o,
  output logic            byte_first_o,
  output logic            selected_o,
  output logic            standby_o
);

  // Frame logic is cleared by chip select high, so no phase, count, shift or output state survives a frame
  logic link_rst;
  assign link_rst = reset_i | cs_n_i; // RULE4 RULE3

  // ---------------- Link domain, rising edge ----------------
  sfp_pkg::sfp_phase_e phase_r;
  sfp_pkg::sfp_width_e width_r;
  logic [2:0]          bit_cnt_r;
  logic [2:0]          byte_cnt_r;
  logic [3:0]          dummy_cnt_r;
  logic [6:0]          shift_r;
  logic [7:0]          full_byte;
  logic                byte_done;

  assign full_byte = {shift_r, bidir_lane_zero_i}; // RULE11
  assign byte_done = (bit_cnt_r == `SFP_LAST_BIT) && (phase_r != sfp_pkg::SFP_PH_DUMMY)
                     && (phase_r != sfp_pkg::SFP_PH_OUT);

  always_ff @(posedge sck_i or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_r <= 3'h0;
      shift_r   <= 7'h00;
    end else if (phase_r != sfp_pkg::SFP_PH_OUT && phase_r != sfp_pkg::SFP_PH_DUMMY) begin
      bit_cnt_r <= bit_cnt_r + 3'h1; // RULE6 RULE8
      shift_r   <= full_byte[6:0];
    end
  end

  always_ff @(posedge sck_i or posedge link_rst) begin
    if (link_rst) begin
      phase_r     <= sfp_pkg::SFP_PH_CMD;
      width_r     <= sfp_pkg::SFP_W_NONE;
      byte_cnt_r  <= 3'h0;
      dummy_cnt_r <= 4'h0;
    end else begin
      case (phase_r)
        sfp_pkg::SFP_PH_CMD: begin
          if (byte_done) begin
            width_r <= sfp_pkg::read_width(full_byte);
            phase_r <= (sfp_pkg::read_width(full_byte) == sfp_pkg::SFP_W_NONE) ?
                       sfp_pkg::SFP_PH_IN : sfp_pkg::SFP_PH_ADDR; // RULE11
          end
        end
        sfp_pkg::SFP_PH_ADDR: begin
          if (byte_done) begin
            byte_cnt_r <= byte_cnt_r + 3'h1;
            if (byte_cnt_r == `SFP_ADDR_BYTES - 3'h1) begin
              phase_r <= sfp_pkg::SFP_PH_DUMMY;
            end
          end
        end
        sfp_pkg::SFP_PH_DUMMY: begin
          dummy_cnt_r <= dummy_cnt_r + 4'h1;
          if (dummy_cnt_r == `SFP_DUMMY_CLKS - 4'h1) begin
            phase_r <= sfp_pkg::SFP_PH_OUT;
          end
        end
        sfp_pkg::SFP_PH_OUT: phase_r <= sfp_pkg::SFP_PH_OUT; // RULE9
        sfp_pkg::SFP_PH_IN:  phase_r <= sfp_pkg::SFP_PH_IN;
        default:             phase_r <= sfp_pkg::SFP_PH_CMD;
      endcase
    end
  end

  // Byte hand-off kept out of the frame reset so a byte survives chip select rise
  logic [7:0] in_byte_r;
  logic       in_first_r;
  logic       in_tgl_r;

  always_ff @(posedge sck_i or posedge reset_i) begin
    if (reset_i) begin
      in_byte_r  <= `SFP_BYTE_RST;
      in_first_r <= 1'b0;
      in_tgl_r   <= 1'b0;
    end else if (!cs_n_i && byte_done) begin // RULE3
      in_byte_r  <= full_byte;
      in_first_r <= (phase_r == sfp_pkg::SFP_PH_CMD);
      in_tgl_r   <= ~in_tgl_r;
    end
  end

  // ---------------- Link domain, falling edge ----------------
  logic [7:0] rd_hold_r;
  logic [7:0] out_sr_r;
  logic [3:0] out_left_r;
  logic [3:0] out_lanes_r;
  logic       drive_r;
  logic       rd_tgl_r;
  logic       load;
  logic [7:0] cur;
  logic [3:0] nlanes;

  assign nlanes = sfp_pkg::lane_count(width_r);
  assign load   = (phase_r == sfp_pkg::SFP_PH_OUT) && (out_left_r == 4'h0);
  assign cur    = load ? rd_hold_r : out_sr_r;

  // Mode 3 leading falling edge lands in the command phase and is harmless
  always_ff @(negedge sck_i or posedge link_rst) begin
    if (link_rst) begin
      out_sr_r    <= 8'h00;
      out_left_r  <= 4'h0;
      out_lanes_r <= 4'h0;
      drive_r     <= 1'b0;
    end else if (phase_r == sfp_pkg::SFP_PH_OUT) begin // RULE10
      drive_r    <= 1'b1;
      out_sr_r   <= cur << nlanes; // RULE7
      out_left_r <= (load ? `SFP_BITS_PER_BYTE : out_left_r) - nlanes;
      case (width_r)
        sfp_pkg::SFP_W_X4: out_lanes_r <= cur[7:4]; // RULE9
        sfp_pkg::SFP_W_X2: out_lanes_r <= {2'b00, cur[7:6]};
        default:           out_lanes_r <= {2'b00, cur[7], 1'b0};
      endcase
    end
  end

  always_ff @(negedge sck_i or posedge reset_i) begin
    if (reset_i) begin
      rd_tgl_r <= 1'b0;
    end else if (!cs_n_i && load) begin
      rd_tgl_r <= ~rd_tgl_r;
    end
  end

  // Outputs float the moment chip select rises, not at the next clock
  assign lane_one_o           = (width_r == sfp_pkg::SFP_W_X1) ? out_lanes_r[1] :
                                (width_r == sfp_pkg::SFP_W_X2) ? out_lanes_r[1] : out_lanes_r[1];
  assign lane_one_oe_o        = ~cs_n_i & drive_r; // RULE2
  assign bidir_lane_zero_o    = out_lanes_r[0];
  assign bidir_lane_zero_oe_o = ~cs_n_i & drive_r & (width_r != sfp_pkg::SFP_W_X1); // RULE9 RULE2
  assign lane_hi_o            = out_lanes_r[3:2];
  assign lane_hi_oe_o         = ~cs_n_i & drive_r & (width_r == sfp_pkg::SFP_W_X4);

  // ---------------- System domain ----------------
  logic [2:0] sync_q;
  logic       cs_n_s;
  logic       in_tgl_s;
  logic       rd_tgl_s;
  logic       in_tgl_d_r;
  logic       rd_tgl_d_r;
  logic [2:0] sys_cnt_r;
  logic       sys_read_r;

  sfp_sync #(
    .WIDTH   (3),
    .RST_VAL ({15'h0000, `SFP_CS_N_RST} << 2)
  ) u_sync (
    .clk_i   (ref_clk_i),
    .reset_i (reset_i),
    .d_i     ({cs_n_i, in_tgl_r, rd_tgl_r}),
    .q_o     (sync_q)
  );

  assign cs_n_s   = sync_q[2];
  assign in_tgl_s = sync_q[1];
  assign rd_tgl_s = sync_q[0];

  assign selected_o = ~cs_n_s; // RULE1
  assign standby_o  = cs_n_s & ~busy_i; // RULE5 RULE2

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      in_tgl_d_r <= 1'b0;
      rd_tgl_d_r <= 1'b0;
    end else begin
      in_tgl_d_r <= in_tgl_s;
      rd_tgl_d_r <= rd_tgl_s;
    end
  end

  // Link byte register is stable for a whole byte time after its toggle
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      byte_valid_o <= 1'b0;
      byte_o       <= `SFP_BYTE_RST;
      byte_first_o <= 1'b0;
      sys_cnt_r    <= 3'h0;
      sys_read_r   <= 1'b0;
    end else begin
      byte_valid_o <= in_tgl_s ^ in_tgl_d_r;
      if (in_tgl_s ^ in_tgl_d_r) begin
        byte_o       <= in_byte_r;
        byte_first_o <= in_first_r;
        sys_cnt_r    <= in_first_r ? 3'h0 : sys_cnt_r + 3'h1;
        if (in_first_r) begin
          sys_read_r <= (sfp_pkg::read_width(in_byte_r) != sfp_pkg::SFP_W_NONE);
        end
      end
    end
  end

  // Prefetch first read byte on the last address byte, then one per load
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_req_o <= 1'b0;
    end else begin
      rd_req_o <= (rd_tgl_s ^ rd_tgl_d_r) ||
                  ((in_tgl_s ^ in_tgl_d_r) && !in_first_r && sys_read_r
                   && (sys_cnt_r == `SFP_ADDR_BYTES - 3'h1));
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_hold_r <= `SFP_BYTE_RST;
    end else if (rd_valid_i) begin
      rd_hold_r <= rd_data_i;
    end
  end

endmodule : sfp_front

// file: rtl/sfp_pkg.sv
`include "sfp_consts.svh"

package sfp_pkg;

  typedef enum logic [2:0] {
    SFP_PH_CMD,
    SFP_PH_ADDR,
    SFP_PH_DUMMY,
    SFP_PH_OUT,
    SFP_PH_IN
  } sfp_phase_e;

  typedef enum logic [1:0] {
    SFP_W_NONE,
    SFP_W_X1,
    SFP_W_X2,
    SFP_W_X4
  } sfp_width_e;

  // Output lane width of a command; none for every non-read command
  function automatic sfp_width_e read_width(input logic [7:0] cmd);
    sfp_width_e w;
    w = SFP_W_NONE;
    case (cmd)
      `SFP_CMD_READ_X1: w = SFP_W_X1;
      `SFP_CMD_READ_X2: w = SFP_W_X2;
      `SFP_CMD_READ_X4: w = SFP_W_X4;
      default:          w = SFP_W_NONE;
    endcase
    return w;
  endfunction : read_width

  function automatic logic [3:0] lane_count(input sfp_width_e w);
    logic [3:0] n;
    n = 4'h1;
    case (w)
      SFP_W_X2: n = 4'h2;
      SFP_W_X4: n = 4'h4;
      default:  n = 4'h1;
    endcase
    return n;
  endfunction : lane_count

endpackage : sfp_pkg

// file: rtl/sfp_sync.sv
`timescale 1ns/1ps

module sfp_sync #(
  parameter int          WIDTH   = 1,
  parameter logic [15:0] RST_VAL = 16'h0000
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_r <= RST_VAL[WIDTH-1:0];
      q_o    <= RST_VAL[WIDTH-1:0];
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule : sfp_sync

// file: verif/serial_flash_pin_interface_tb.sv
`timescale 1ns/1ps
`include "sfp_consts.svh"

module serial_flash_pin_interface_tb;
  logic       ref_clk_i, reset_i, busy_i, rd_valid_i, sck, cs_n, mosi, lane0;
  logic       l0_o, l0_oe, l1_o, l1_oe, hi_oe, rd_req, bv, bf, sel, stby;
  logic [1:0] hi_o;
  logic [7:0] rd_data_i, pat, byte_w, b;
  logic [8:0] got[$];
  int         err_count, checks;
  assign lane0 = l0_oe ? l0_o : mosi;
  always #2.5 ref_clk_i = ~ref_clk_i;
  sfp_front sfp_front_i (.ref_clk_i, .reset_i, .sck_i(sck), .cs_n_i(cs_n), .bidir_lane_zero_i(lane0),
    .bidir_lane_zero_o(l0_o), .bidir_lane_zero_oe_o(l0_oe), .lane_one_o(l1_o), .lane_one_oe_o(l1_oe),
    .lane_hi_o(hi_o), .lane_hi_oe_o(hi_oe), .busy_i, .rd_data_i, .rd_valid_i, .rd_req_o(rd_req),
    .byte_valid_o(bv), .byte_o(byte_w), .byte_first_o(bf), .selected_o(sel), .standby_o(stby));
  // Released lanes show the inverse, so a late output enable reads as bad data
  sfp_host sfp_host_i (.sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi), .lane_zero_i(lane0),
    .lane_one_i(l1_oe ? l1_o : ~l1_o), .lane_hi_i(hi_oe ? hi_o : ~hi_o));
  // Array side answers each request one cycle later
  always @(negedge ref_clk_i) begin
    rd_valid_i <= rd_req;
    if (rd_req) begin
      rd_data_i <= pat;
      pat <= pat + 8'h11;
    end
    if (bv) got.push_back({bf, byte_w});
  end
  task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic s_write(input logic m3);
    got.delete();
    sfp_host_i.start(m3);
    sfp_host_i.send(8'h02);
    chk("sel", sel, 9'h001);
    sfp_host_i.send(8'h5A);
    sfp_host_i.send(8'hC3);
    sfp_host_i.stop();
    for (int i = 0; i < 60 && got.size() < 3; i++) @(negedge ref_clk_i);
    if (got.size() < 3) begin
      chk("count", 9'(got.size()), 9'h003);
      give_verdict();
    end
    chk("cmd", got[0], 9'h102);
    chk("byte1", got[1], 9'h05A);
    chk("byte2", got[2], 9'h0C3);
    chk("sel", sel, 9'h000);
  endtask : s_write
  task automatic s_read(input logic [7:0] cmd, input int n);
    pat = 8'hA5;
    got.delete();
    sfp_host_i.start(n == 2); // Dual read in mode 3
    sfp_host_i.send(cmd);
    for (int i = 0; i < 3; i++) sfp_host_i.send(8'h10 + 8'(i));
    repeat (8) sfp_host_i.tick(1'b0, 1'b0);
    sfp_host_i.recv(n, b);
    chk("rd0", b, 9'h0A5);
    chk("oe", {l0_oe, l1_oe, hi_oe}, {n > 1, 1'b1, n > 2});
    sfp_host_i.recv(n, b);
    chk("rd1", b, 9'h0B6);
    sfp_host_i.stop();
    chk("oe", {l0_oe, l1_oe, hi_oe}, 9'h000);
    chk("taken", 9'(got.size()), 9'h004);
  endtask : s_read
  task automatic s_desel();
    got.delete();
    repeat (16) sfp_host_i.tick(1'b1, 1'b1);
    sfp_host_i.stop();
    chk("taken", 9'(got.size()), 9'h000);
    // Cut frame: one whole byte, then four stray bits that the next frame must not inherit
    sfp_host_i.start(1'b0);
    repeat (12) sfp_host_i.tick(1'b1, 1'b1);
    sfp_host_i.stop();
    chk("cut", 9'(got.size()), 9'h001);
  endtask : s_desel
  task automatic s_busy();
    @(negedge ref_clk_i) busy_i = 1'b1;
    @(negedge ref_clk_i) chk("stby", stby, 9'h000);
    @(negedge ref_clk_i) busy_i = 1'b0;
    @(negedge ref_clk_i) chk("stby", stby, 9'h001);
  endtask : s_busy
  initial begin
    ref_clk_i = 1'b0;
    reset_i = 1'b1;
    busy_i = 1'b0;
    rd_valid_i = 1'b0;
    rd_data_i = 8'h00;
    pat = 8'hA5;
    err_count = 0;
    checks = 0;
    repeat (12) @(negedge ref_clk_i);
    reset_i = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    chk("stby", stby, 9'h001);
    chk("sel", sel, 9'h000);
    s_write(1'b0);
    s_write(1'b1);
    s_desel();
    s_read(`SFP_CMD_READ_X1, 1);
    s_read(`SFP_CMD_READ_X2, 2);
    s_read(`SFP_CMD_READ_X4, 4);
    s_busy();
    give_verdict();
  end
endmodule : serial_flash_pin_interface_tb

// file: verif/sfp_front_assertions.sv
`timescale 1ns/1ps

module sfp_front_chk (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic busy_i,
  input wire logic bidir_lane_zero_oe_o,
  input wire logic lane_one_o,
  input wire logic lane_one_oe_o,
  input wire logic lane_hi_oe_o,
  input wire logic byte_valid_o,
  input wire logic selected_o,
  input wire logic standby_o
);
  // Lane level just before each rise, to spot a change in the high phase
  logic l1_rise_r;
  always_ff @(posedge sck_i) l1_rise_r <= lane_one_o;

  a_oe_off_desel: assert property (
    @(posedge ref_clk_i) disable iff (reset_i) cs_n_i |-> !(bidir_lane_zero_oe_o || lane_one_oe_o || lane_hi_oe_o))
    else $error("lane driven while deselected");
  a_standby_busy: assert property (
    @(posedge ref_clk_i) disable iff (reset_i) busy_i |-> !standby_o)
    else $error("standby while busy");
  a_sel_low: assert property (
    @(posedge ref_clk_i) disable iff (reset_i) !cs_n_i [*4] |=> selected_o && !standby_o)
    else $error("not selected with select low");
  a_sel_high: assert property (
    @(posedge ref_clk_i) disable iff (reset_i) cs_n_i [*4] |=> !selected_o && standby_o == !busy_i)
    else $error("no standby after release");
  a_no_byte_desel: assert property (
    @(posedge ref_clk_i) disable iff (reset_i) cs_n_i [*6] |-> !byte_valid_o)
    else $error("byte taken while deselected");
  a_byte_pulse: assert property (
    @(posedge ref_clk_i) disable iff (reset_i) byte_valid_o |=> !byte_valid_o)
    else $error("byte strobe too long");
  a_lane1_fall: assert property (
    @(negedge sck_i) disable iff (reset_i || cs_n_i) lane_one_oe_o |-> lane_one_o == l1_rise_r)
    else $error("read lane changed on a rise");
  a_quad_lanes: assert property (
    @(posedge ref_clk_i) disable iff (reset_i) lane_hi_oe_o |-> lane_one_oe_o && bidir_lane_zero_oe_o)
    else $error("quad lanes incomplete");
endmodule : sfp_front_chk

bind sfp_front sfp_front_chk sfp_front_chk_i (.ref_clk_i, .reset_i, .sck_i, .cs_n_i, .busy_i,
  .bidir_lane_zero_oe_o, .lane_one_o, .lane_one_oe_o, .lane_hi_oe_o, .byte_valid_o, .selected_o, .standby_o);

// file: verif/sfp_host.sv
`timescale 1ns/1ps

module sfp_host (
  output logic            sck_o,
  output logic            cs_n_o,
  output logic            mosi_o,
  input  wire logic       lane_zero_i,
  input  wire logic       lane_one_i,
  input  wire logic [1:0] lane_hi_i
);
  logic       idle_hi;
  logic [3:0] lanes;
  initial begin
    idle_hi = 1'b0;
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // Fall first, so device data settles before the rising sample
  task automatic tick(input logic drv, input logic bit_v);
    sck_o = 1'b0;
    mosi_o = drv ? bit_v : ~mosi_o; // Released lane toggles, never stale
    #16 sck_o = 1'b1;
    lanes = {lane_hi_i, lane_one_i, lane_zero_i};
    #16;
  endtask : tick
  task automatic start(input logic m3);
    idle_hi = m3;
    sck_o = m3;
    #23 cs_n_o = 1'b0;
    #20;
  endtask : start
  task automatic stop();
    sck_o = idle_hi;
    #20 cs_n_o = 1'b1;
    #40;
  endtask : stop
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) tick(1'b1, b[i]);
  endtask : send
  task automatic recv(input int n, output logic [7:0] b);
    for (int i = 0; i < 8 / n; i++) begin
      tick(1'b0, 1'b0);
      case (n)
        1: b = {b[6:0], lanes[1]};
        2: b = {b[5:0], lanes[1:0]};
        default: b = {b[3:0], lanes};
      endcase
    end
  endtask : recv
endmodule : sfp_host
